// ### design/rmp_top.sv
/*
  Output selectors for remappable pins 10..21 with their AXI4-Lite register
  file and the per-pin routing to the pads. Assumes peripheral outputs come
  from logic on the core clock; the pad takes port control while drive is low.
*/
module rmp_top
  import rmp_pkg::*;
#(
  // set for the smallest package, where pin 15 does not exist
  parameter bit PKG_SMALL = 1'b0
) (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // axi write address
  input wire logic I_AWVALID,
  input wire logic [31:0] I_AWADDR,
  input wire logic [2:0] I_AWPROT,
  output logic O_AWREADY,
  // axi write data
  input wire logic I_WVALID,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_WREADY,
  // axi write response
  output logic O_BVALID,
  output logic [1:0] O_BRESP,
  input wire logic I_BREADY,
  // axi read address
  input wire logic I_ARVALID,
  input wire logic [31:0] I_ARADDR,
  input wire logic [2:0] I_ARPROT,
  output logic O_ARREADY,
  // axi read data
  output logic O_RVALID,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic I_RREADY,
  // peripheral outputs, indexed by output number
  input wire logic [NUM_FUNCS-1:0] I_PERIPH_OUT,
  // pad drivers, bit 0 is pin 10
  output logic [NUM_PINS-1:0] O_PIN_OUT,
  output logic [NUM_PINS-1:0] O_PIN_OE
);
  rmp_reg_if reg_bus ();

  logic [SEL_W-1:0] sel_reg [NUM_PINS];
  logic [SEL_W-1:0] sel_next [NUM_PINS];
  logic [NUM_PINS-1:0] pin_level, pin_drive;
  logic [NUM_PINS-1:0] pin_out_reg, pin_out_next, pin_oe_reg, pin_oe_next;
  logic [3:0] even_slot, odd_slot, rd_even, rd_odd;
  logic prot_unused;

  // protection bits carry no meaning for these registers
  assign prot_unused = ^{I_AWPROT, I_ARPROT};

  rmp_axil_front u_front (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_awvalid(I_AWVALID),
    .i_awaddr(I_AWADDR),
    .o_awready(O_AWREADY),
    .i_wvalid(I_WVALID),
    .i_wdata(I_WDATA),
    .i_wstrb(I_WSTRB),
    .o_wready(O_WREADY),
    .o_bvalid(O_BVALID),
    .o_bresp(O_BRESP),
    .i_bready(I_BREADY),
    .i_arvalid(I_ARVALID),
    .i_araddr(I_ARADDR),
    .o_arready(O_ARREADY),
    .o_rvalid(O_RVALID),
    .o_rdata(O_RDATA),
    .o_rresp(O_RRESP),
    .i_rready(I_RREADY),
    .regs(reg_bus.host)
  );

  // selector register file
  always_comb begin
    even_slot = {reg_bus.wr_idx, 1'b0};
    odd_slot = {reg_bus.wr_idx, 1'b1};
    for (int p = 0; p < NUM_PINS; p++) begin
      sel_next[p] = sel_reg[p];
    end
    if (reg_bus.wr_en) begin
      // R2 even pin low byte lane
      if (reg_bus.wr_strb[0]) begin
        sel_next[even_slot] = reg_bus.wr_data[EVEN_LSB +: SEL_W];
      end
      // R2 odd pin high byte lane
      if (reg_bus.wr_strb[1]) begin
        sel_next[odd_slot] = reg_bus.wr_data[ODD_LSB +: SEL_W];
      end
    end
    // R5 pin 15 absent on small package
    if (PKG_SMALL) begin
      sel_next[PIN15_SLOT] = SEL_RST;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    // R4 clear on reset
    if (I_RST) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        sel_reg[p] <= SEL_RST;
      end
    end else begin
      for (int p = 0; p < NUM_PINS; p++) begin
        sel_reg[p] <= sel_next[p];
      end
    end
  end

  // R3 unimplemented bits read zero
  always_comb begin
    rd_even = {reg_bus.rd_idx, 1'b0};
    rd_odd = {reg_bus.rd_idx, 1'b1};
    reg_bus.rd_data = 16'h0000;
    if (rd_odd < 4'(NUM_PINS)) begin
      reg_bus.rd_data = {2'h0, sel_reg[rd_odd], 2'h0, sel_reg[rd_even]};
    end
  end

  // one router per pin
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_route
    rmp_pin_route u_route (
      .i_sel(sel_reg[g]),
      .i_periph(I_PERIPH_OUT),
      .o_level(pin_level[g]),
      .o_drive(pin_drive[g])
    );
  end

  // pads see a registered copy so a selector change never glitches them
  always_comb begin
    pin_out_next = pin_level;
    pin_oe_next = pin_drive;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      pin_out_reg <= 12'h000;
      pin_oe_reg <= 12'h000;
    end else begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  assign O_PIN_OUT = pin_out_reg;
  assign O_PIN_OE = pin_oe_reg;

  // checks
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);

  logic pin10_pick, pin10_known, pin21_pick, pin21_known;
  assign pin10_pick = I_PERIPH_OUT[sel_reg[0]];
  assign pin10_known = FUNC_IMPL_MASK[sel_reg[0]];
  assign pin21_pick = I_PERIPH_OUT[sel_reg[NUM_PINS-1]];
  assign pin21_known = FUNC_IMPL_MASK[sel_reg[NUM_PINS-1]];

  chk_route_pin10: assert property ( // R1
    (sel_reg[0] != SEL_NONE) && pin10_known
      |=> O_PIN_OE[0] && (O_PIN_OUT[0] == $past(pin10_pick)))
    else $error("pin 10 does not carry the selected output");

  chk_route_pin21: assert property ( // R1
    (sel_reg[NUM_PINS-1] != SEL_NONE) && pin21_known
      |=> O_PIN_OE[NUM_PINS-1] && (O_PIN_OUT[NUM_PINS-1] == $past(pin21_pick)))
    else $error("pin 21 does not carry the selected output");

  chk_field_layout: assert property ( // R2
    reg_bus.wr_en && (reg_bus.wr_idx == 3'h0) && (reg_bus.wr_strb == 2'h3)
      |=> (sel_reg[1] == $past(reg_bus.wr_data[13:8]))
          && (sel_reg[0] == $past(reg_bus.wr_data[5:0])))
    else $error("pin pair 10/11 fields landed in the wrong bits");

  chk_lane_keep: assert property ( // R2
    reg_bus.wr_en && (reg_bus.wr_idx == 3'h2) && (reg_bus.wr_strb == 2'h1)
      |=> $stable(sel_reg[5]) ##1 $stable(sel_reg[5]) || !PKG_SMALL)
    else $error("pin 15 field changed without its byte lane");

  chk_reserved_zero: assert property ( // R3
    O_RVALID |-> (O_RDATA[31:14] == 18'h00000) && (O_RDATA[7:6] == 2'h0))
    else $error("unimplemented selector bits read as one");

  chk_reset_clear: assert property (@(posedge I_CORE_CLK) disable iff (1'b0) // R4
    I_RST |=> (sel_reg[0] == SEL_RST) && (sel_reg[7] == SEL_RST)
              && (O_PIN_OE == 12'h000))
    else $error("selectors not cleared by reset");

  chk_readback: assert property ( // R4
    I_ARVALID && O_ARREADY && (I_ARADDR == OFS_SEL_16_17)
      |=> O_RVALID && (O_RDATA[5:0] == $past(sel_reg[6]))
          && (O_RDATA[13:8] == $past(sel_reg[7])) && (O_RRESP == RESP_OKAY))
    else $error("selector read back wrong");

  chk_small_pin15: assert property ( // R5
    PKG_SMALL |-> (sel_reg[PIN15_SLOT] == SEL_RST) && !O_PIN_OE[PIN15_SLOT])
    else $error("pin 15 selector present on small package");

  chk_idle_undriven: assert property ( // R6
    (sel_reg[2] == SEL_NONE) || !FUNC_IMPL_MASK[sel_reg[2]] |=> !O_PIN_OE[2])
    else $error("pin 12 driven with no valid selection");

  chk_write_answer: assert property (
    reg_bus.wr_en |=> O_BVALID && (O_BRESP == RESP_OKAY))
    else $error("write not answered one cycle later");

  chk_read_hold: assert property (
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped before it was taken");

  // expected pad state per pin, worked out apart from the router instances
  logic [NUM_PINS-1:0] want_oe, want_out;

  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      want_oe[p] = (sel_reg[p] != SEL_NONE) && FUNC_IMPL_MASK[sel_reg[p]];
      want_out[p] = want_oe[p] && I_PERIPH_OUT[sel_reg[p]];
    end
  end

  // pads, all twelve at once
  chk_all_enables: assert property ( // R6
    1'b1 |=> O_PIN_OE == $past(want_oe))
    else $error("pad enables do not follow the selectors");

  chk_all_levels: assert property ( // R1
    1'b1 |=> O_PIN_OUT == $past(want_out))
    else $error("pad levels do not follow the selected outputs");

  // a released pad must not leave a stale level behind for the port logic
  chk_level_when_off: assert property ( // R6
    (O_PIN_OUT & ~O_PIN_OE) == 12'h000)
    else $error("pad level high while not driven");

  // register fields
  chk_lane_even_keep: assert property ( // R2
    reg_bus.wr_en && (reg_bus.wr_idx == 3'h0) && (reg_bus.wr_strb == 2'h2)
      |=> $stable(sel_reg[0]))
    else $error("pin 10 field changed without its byte lane");

  chk_pin15_store: assert property ( // R2
    !PKG_SMALL && reg_bus.wr_en && (reg_bus.wr_idx == 3'h2) && reg_bus.wr_strb[1]
      |=> (sel_reg[PIN15_SLOT] == $past(reg_bus.wr_data[13:8])))
    else $error("pin 15 field not stored on the full package");

  chk_small_read15: assert property ( // R5
    PKG_SMALL && I_ARVALID && O_ARREADY && (I_ARADDR == OFS_SEL_14_15)
      |=> (O_RDATA[13:8] == 6'h00))
    else $error("pin 15 field reads nonzero on small package");

  // bus handshakes; one transfer per direction keeps the front end free of queues
  chk_reset_ready: assert property (@(posedge I_CORE_CLK) disable iff (1'b0)
    I_RST |=> !O_AWREADY && !O_WREADY && !O_ARREADY && !O_BVALID && !O_RVALID)
    else $error("bus not idle after reset");

  chk_write_taken: assert property (
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
      |=> O_BVALID && !O_AWREADY && !O_WREADY)
    else $error("write taken but not answered next cycle");

  chk_read_taken: assert property (
    I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY)
    else $error("read taken but not answered next cycle");

  chk_one_write: assert property (
    O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("new write offered while a response is pending");

  chk_one_read: assert property (
    O_RVALID |-> !O_ARREADY)
    else $error("new read offered while read data is pending");

  chk_bresp_hold: assert property (
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped before it was taken");

  chk_write_release: assert property (
    O_BVALID && I_BREADY |=> !O_BVALID && O_AWREADY && O_WREADY)
    else $error("write channel not free after its response");

  chk_read_release: assert property (
    O_RVALID && I_RREADY |=> !O_RVALID && O_ARREADY)
    else $error("read channel not free after its data");

  // an unmapped read must not leak a selector value
  chk_unmapped_zero: assert property (
    O_RVALID && (O_RRESP == RESP_SLVERR) |-> (O_RDATA == 32'h0000_0000))
    else $error("unmapped read returned data");

  cov_write_pair: cover property (reg_bus.wr_en && (reg_bus.wr_strb == 2'h3));
  cov_pin_routed: cover property (!O_PIN_OE[0] ##1 O_PIN_OE[0]);
  cov_unmapped_read: cover property (O_RVALID && (O_RRESP == RESP_SLVERR));
  cov_read_stall: cover property (O_RVALID && !I_RREADY ##1 O_RVALID);
  cov_write_stall: cover property (O_BVALID && !I_BREADY ##1 O_BVALID);
endmodule : rmp_top

// ### design/rmp_pkg.sv
/*
  Shared constants for the remappable output selector block (pins 10..21):
  register offsets, field layout, reset values, bus answers, address decode.
  Assumes a 32-bit AXI4-Lite register bus and a 64-entry peripheral output set.
*/
// Contract
// R1: each pin carries the peripheral output whose number its 6-bit selector holds.
// R2: odd pin selector in bits 13..8, even pin in bits 5..0, pairs 10/11..20/21.
// R3: bits 15..14 and 7..6 ignore writes and read as zero.
// R4: every selector field is read/write and clears to zero at reset.
// R5: on the small package the pin 15 selector is absent, reads zero.
// R6: code zero or an unknown code leaves the pin to ordinary port control.
package rmp_pkg;
  localparam int SEL_W = 6;
  localparam int NUM_PINS = 12;
  localparam int NUM_FUNCS = 64;
  localparam int IDX_W = 3;
  localparam int EVEN_LSB = 0;
  localparam int ODD_LSB = 8;
  localparam int REG_W = 16;
  // slot of pin 15 counted from pin 10
  localparam int PIN15_SLOT = 5;
  localparam logic [SEL_W-1:0] SEL_RST = 6'h00;
  localparam logic [SEL_W-1:0] SEL_NONE = 6'h00;
  localparam logic [31:0] OFS_SEL_10_11 = 32'h0000_0000;
  localparam logic [31:0] OFS_SEL_12_13 = 32'h0000_0004;
  localparam logic [31:0] OFS_SEL_14_15 = 32'h0000_0008;
  localparam logic [31:0] OFS_SEL_16_17 = 32'h0000_000c;
  localparam logic [31:0] OFS_SEL_18_19 = 32'h0000_0010;
  localparam logic [31:0] OFS_SEL_20_21 = 32'h0000_0014;
  // output numbers that really exist on this chip; bit n set means code n drives
  localparam logic [NUM_FUNCS-1:0] FUNC_IMPL_MASK = 64'h0000_0000_ffff_fffe;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // returns {hit, register index}; the two low address bits are ignored
  function automatic logic [IDX_W:0] decode_ofs(input logic [31:0] addr);
    logic [31:0] word;
    word = {addr[31:2], 2'h0};
    case (word)
      OFS_SEL_10_11: decode_ofs = 4'h8;
      OFS_SEL_12_13: decode_ofs = 4'h9;
      OFS_SEL_14_15: decode_ofs = 4'ha;
      OFS_SEL_16_17: decode_ofs = 4'hb;
      OFS_SEL_18_19: decode_ofs = 4'hc;
      OFS_SEL_20_21: decode_ofs = 4'hd;
      default: decode_ofs = 4'h0;
    endcase
  endfunction : decode_ofs
endpackage : rmp_pkg

// ### design/rmp_reg_if.sv
/*
  Carrier between the bus front end and the selector register file.
  Assumes both ends run on the same core clock; all signals are combinational.
*/
interface rmp_reg_if
  import rmp_pkg::*;
;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [REG_W-1:0] wr_data;
  logic [1:0] wr_strb;
  logic [IDX_W-1:0] rd_idx;
  logic [REG_W-1:0] rd_data;

  modport host (output wr_en, output wr_idx, output wr_data, output wr_strb,
                output rd_idx, input rd_data);
  modport regs (input wr_en, input wr_idx, input wr_data, input wr_strb,
                input rd_idx, output rd_data);
endinterface : rmp_reg_if

// ### design/rmp_axil_front.sv
/*
  AXI4-Lite slave front end: one write and one read under way at a time.
  Assumes a master on the same clock; unmapped addresses answer SLVERR.
*/
module rmp_axil_front
  import rmp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // write address and data
  input wire logic i_awvalid,
  input wire logic [31:0] i_awaddr,
  output logic o_awready,
  input wire logic i_wvalid,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_wready,
  // write response
  output logic o_bvalid,
  output logic [1:0] o_bresp,
  input wire logic i_bready,
  // read
  input wire logic i_arvalid,
  input wire logic [31:0] i_araddr,
  output logic o_arready,
  output logic o_rvalid,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_rready,
  // register file
  rmp_reg_if.host regs
);
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [31:0] awaddr_reg, awaddr_next;
  logic [REG_W-1:0] wdata_reg, wdata_next;
  logic [1:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic arready_reg, arready_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic aw_hs, w_hs, ar_hs, do_wr;
  logic [IDX_W:0] wr_dec, rd_dec;

  always_comb begin
    aw_hs = i_awvalid && awready_reg;
    w_hs = i_wvalid && wready_reg;
    ar_hs = i_arvalid && arready_reg;
    // the write lands in the cycle its second half is taken
    do_wr = (aw_held_reg || aw_hs) && (w_held_reg || w_hs);
    wr_dec = decode_ofs(aw_held_reg ? awaddr_reg : i_awaddr);
    rd_dec = decode_ofs(i_araddr);
    regs.wr_en = do_wr && wr_dec[IDX_W];
    regs.wr_idx = wr_dec[IDX_W-1:0];
    regs.wr_data = w_held_reg ? wdata_reg : i_wdata[REG_W-1:0];
    regs.wr_strb = w_held_reg ? wstrb_reg : i_wstrb[1:0];
    regs.rd_idx = rd_dec[IDX_W-1:0];
    aw_held_next = (aw_held_reg || aw_hs) && !do_wr;
    w_held_next = (w_held_reg || w_hs) && !do_wr;
    awaddr_next = aw_hs ? i_awaddr : awaddr_reg;
    wdata_next = w_hs ? i_wdata[REG_W-1:0] : wdata_reg;
    wstrb_next = w_hs ? i_wstrb[1:0] : wstrb_reg;
    bvalid_next = do_wr || (bvalid_reg && !i_bready);
    bresp_next = bresp_reg;
    if (do_wr) begin
      bresp_next = wr_dec[IDX_W] ? RESP_OKAY : RESP_SLVERR;
    end
    rvalid_next = ar_hs || (rvalid_reg && !i_rready);
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (ar_hs) begin
      rdata_next = rd_dec[IDX_W] ? {16'h0000, regs.rd_data} : 32'h0000_0000;
      rresp_next = rd_dec[IDX_W] ? RESP_OKAY : RESP_SLVERR;
    end
    // no new write is taken while its response is still pending
    awready_next = !aw_held_next && !bvalid_next;
    wready_next = !w_held_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 32'h0000_0000;
      wdata_reg <= 16'h0000;
      wstrb_reg <= 2'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      arready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      arready_reg <= arready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign o_awready = awready_reg;
  assign o_wready = wready_reg;
  assign o_arready = arready_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
endmodule : rmp_axil_front

// ### design/rmp_pin_route.sv
/*
  One pin's output router: picks a peripheral output by its selector code.
  Assumes the caller registers the result before it reaches the pad.
*/
module rmp_pin_route
  import rmp_pkg::*;
(
  // selector and peripheral outputs
  input wire logic [SEL_W-1:0] i_sel,
  input wire logic [NUM_FUNCS-1:0] i_periph,
  // pad side
  output logic o_level,
  output logic o_drive
);
  always_comb begin
    // R6 zero or unknown code releases pad
    o_drive = (i_sel != SEL_NONE) && FUNC_IMPL_MASK[i_sel];
    // R1 pick output by number
    o_level = o_drive && i_periph[i_sel];
  end
endmodule : rmp_pin_route

// ### verification/rmp_periph_model.sv
/*
  Source of the peripheral outputs that feed the selector block.
  Assumes the bench sets the wanted levels just after a rising edge.
*/
module rmp_periph_model (
  // clock and wanted levels
  input wire logic i_clk,
  input wire logic [63:0] i_word,
  // peripheral outputs, from flops as real peripherals would give them
  output logic [63:0] o_periph
);
  timeunit 1ns;
  timeprecision 1ps;

  always @(posedge i_clk) begin
    o_periph <= i_word;
  end
endmodule : rmp_periph_model

// ### verification/test_remap_output_select_pins_10_21.sv
/*
  Self-checking bench for the pin 10..21 output selectors.
  Assumes an AXI4-Lite slave; a small-package copy shares the bus and is read alongside.
*/
module test_remap_output_select_pins_10_21
  import rmp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [63:0] word = 64'h0;
  logic [63:0] periph;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rdata2;
  logic [11:0] pin_out, pin_oe, pin_out2, pin_oe2;
  logic [5:0] sel [12] = '{default: 6'h0};
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  rmp_periph_model u_periph (.i_clk(clk), .i_word(word), .o_periph(periph));

  rmp_top dut (
    .I_CORE_CLK(clk), .I_RST(rst),
    .I_AWVALID(awvalid), .I_AWADDR(awaddr), .I_AWPROT(3'h0), .O_AWREADY(awready),
    .I_WVALID(wvalid), .I_WDATA(wdata), .I_WSTRB(wstrb), .O_WREADY(wready),
    .O_BVALID(bvalid), .O_BRESP(bresp), .I_BREADY(bready),
    .I_ARVALID(arvalid), .I_ARADDR(araddr), .I_ARPROT(3'h0), .O_ARREADY(arready),
    .O_RVALID(rvalid), .O_RDATA(rdata), .O_RRESP(rresp), .I_RREADY(rready),
    .I_PERIPH_OUT(periph), .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe)
  );

  // same bus traffic; its handshakes match the main copy cycle for cycle
  rmp_top #(.PKG_SMALL(1'b1)) dut_small (
    .I_CORE_CLK(clk), .I_RST(rst),
    .I_AWVALID(awvalid), .I_AWADDR(awaddr), .I_AWPROT(3'h0), .O_AWREADY(),
    .I_WVALID(wvalid), .I_WDATA(wdata), .I_WSTRB(wstrb), .O_WREADY(),
    .O_BVALID(), .O_BRESP(), .I_BREADY(bready),
    .I_ARVALID(arvalid), .I_ARADDR(araddr), .I_ARPROT(3'h0), .O_ARREADY(),
    .O_RVALID(), .O_RDATA(rdata2), .O_RRESP(), .I_RREADY(rready),
    .I_PERIPH_OUT(periph), .O_PIN_OUT(pin_out2), .O_PIN_OE(pin_oe2)
  );

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s: got %h, want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    bit aw, w, b;
    int n;
    b = 1'b0;
    n = 0;
    r = 2'h3;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    // handshake seen at the negedge holds at the next rising edge
    while (!b && n < 100) begin
      @(negedge clk);
      aw = awvalid && awready === 1'b1;
      w = wvalid && wready === 1'b1;
      b = bvalid === 1'b1;
      r = bresp;
      n++;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
    if (!b) chk(32'h0, 32'h1, "write answer missing");
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [31:0] d2,
                        output logic [1:0] r);
    bit ar, rv;
    int n;
    rv = 1'b0;
    n = 0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!rv && n < 100) begin
      @(negedge clk);
      ar = arvalid && arready === 1'b1;
      rv = rvalid === 1'b1;
      d = rdata;
      d2 = rdata2;
      r = rresp;
      n++;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
      if (rv) rready <= 1'b0;
    end
    if (!rv) chk(32'h0, 32'h1, "read answer missing");
  endtask : axi_rd

  task automatic check_regs();
    logic [31:0] d, d2;
    logic [1:0] r;
    for (int i = 0; i < 6; i++) begin
      axi_rd(OFS_SEL_10_11 + 32'(4 * i), d, d2, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY}, "read resp");
      chk(d, {18'h0, sel[2*i+1], 2'h0, sel[2*i]}, "readback");
      chk(d2, {18'h0, (i == 2) ? 6'h0 : sel[2*i+1], 2'h0, sel[2*i]}, "small readback");
    end
  endtask : check_regs

  task automatic write_all();
    logic [1:0] r;
    // upper bits all ones: the unused bits must drop them
    for (int i = 0; i < 6; i++) begin
      axi_wr(OFS_SEL_10_11 + 32'(4 * i), {16'hffff, 2'h3, sel[2*i+1], 2'h3, sel[2*i]}, 4'hf, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY}, "write resp");
    end
  endtask : write_all

  task automatic check_pins(input logic [63:0] v);
    logic [11:0] eo, ee;
    @(posedge clk);
    word <= v;
    repeat (2) @(posedge clk);
    for (int k = 0; k < 12; k++) begin
      ee[k] = FUNC_IMPL_MASK[sel[k]];
      eo[k] = ee[k] & v[sel[k]];
    end
    @(negedge clk);
    chk({20'h0, pin_oe}, {20'h0, ee}, "pin enables");
    chk({20'h0, pin_out}, {20'h0, eo}, "pin levels");
    ee[PIN15_SLOT] = 1'b0;
    eo[PIN15_SLOT] = 1'b0;
    chk({20'h0, pin_oe2}, {20'h0, ee}, "small pin enables");
    chk({20'h0, pin_out2}, {20'h0, eo}, "small pin levels");
  endtask : check_pins

  task automatic t_reset();
    check_regs();
    check_pins(64'hffff_ffff_ffff_ffff);
    $display("test reset done");
  endtask : t_reset

  task automatic t_route();
    for (int k = 0; k < 12; k++) sel[k] = 6'(2 * k + 3);
    write_all();
    check_regs();
    check_pins(64'ha5c3_0f96_5a3c_f069);
    check_pins(~64'ha5c3_0f96_5a3c_f069);
    $display("test route done");
  endtask : t_route

  task automatic t_codes();
    // codes at both ends of the range and past the known outputs
    sel = '{6'h00, 6'h1f, 6'h20, 6'h3f, 6'h01, 6'h11, 6'h1e, 6'h21, 6'h10, 6'h02, 6'h3e, 6'h05};
    write_all();
    check_regs();
    check_pins(64'hffff_ffff_ffff_ffff);
    check_pins(64'h0123_4567_89ab_cdef);
    $display("test codes done");
  endtask : t_codes

  task automatic t_strobe();
    logic [1:0] r;
    axi_wr(OFS_SEL_10_11, {16'h0, 2'h0, 6'h15, 2'h0, 6'h2a}, 4'h2, r);
    sel[1] = 6'h15;
    axi_wr(OFS_SEL_10_11, {16'h0, 2'h0, 6'h33, 2'h0, 6'h0c}, 4'h1, r);
    sel[0] = 6'h0c;
    axi_wr(OFS_SEL_14_15, 32'hffff_ffff, 4'hc, r);
    axi_wr(OFS_SEL_14_15, 32'h0000_3f2d, 4'h1, r);
    sel[4] = 6'h2d;
    check_regs();
    check_pins(64'h5555_aaaa_3333_cccc);
    $display("test strobe done");
  endtask : t_strobe

  task automatic t_stall();
    int n;
    n = 0;
    // response held back by the master: it must stand until bready
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= OFS_SEL_20_21;
    wvalid <= 1'b1;
    wdata <= {16'h0, 2'h0, 6'h1d, 2'h0, 6'h07};
    wstrb <= 4'h3;
    @(negedge clk);
    while (!(awready === 1'b1 && wready === 1'b1) && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    sel[10] = 6'h07;
    sel[11] = 6'h1d;
    repeat (3) @(posedge clk);
    bready <= 1'b1;
    @(negedge clk);
    chk({31'h0, bvalid}, 32'h1, "stalled write answer");
    chk({30'h0, bresp}, {30'h0, RESP_OKAY}, "stalled write resp");
    @(posedge clk);
    bready <= 1'b0;
    n = 0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= OFS_SEL_20_21;
    @(negedge clk);
    while (arready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    arvalid <= 1'b0;
    repeat (3) @(posedge clk);
    rready <= 1'b1;
    @(negedge clk);
    chk({31'h0, rvalid}, 32'h1, "stalled read answer");
    chk(rdata, {18'h0, sel[11], 2'h0, sel[10]}, "stalled read data");
    @(posedge clk);
    rready <= 1'b0;
    $display("test stall done");
  endtask : t_stall

  task automatic t_rerst();
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    sel = '{default: 6'h0};
    check_regs();
    check_pins(64'hffff_ffff_ffff_ffff);
    $display("test second reset done");
  endtask : t_rerst

  task automatic t_unmapped();
    logic [31:0] d, d2;
    logic [1:0] r;
    axi_wr(32'h18, 32'h3f3f, 4'hf, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write resp");
    axi_rd(32'h18, d, d2, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read resp");
    chk(d, 32'h0, "unmapped read data");
    check_regs();
    $display("test unmapped done");
  endtask : t_unmapped

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_route();
    t_codes();
    t_strobe();
    t_stall();
    t_unmapped();
    t_rerst();
    report_and_stop();
  end
endmodule : test_remap_output_select_pins_10_21
